// [design/pcmv_pkg.sv]
package pcmv_pkg;
   // ***************************************************
   // register byte offsets
   // ***************************************************
   localparam logic [7:0] PCMV_CTRL_OFS = 8'h00;
   localparam logic [7:0] PCMV_DIV_OFS = 8'h04;
   localparam logic [7:0] PCMV_CHAN_OFS = 8'h08;
   localparam logic [7:0] PCMV_STAT_OFS = 8'h0c;
   localparam logic [7:0] PCMV_TX0_OFS = 8'h10;
   localparam logic [7:0] PCMV_RX0_OFS = 8'h1c;
   // ***************************************************
   // control, divider and channel field positions
   // ***************************************************
   localparam int PCMV_EN_BIT = 0;
   localparam int PCMV_MST_BIT = 1;
   localparam int PCMV_LONG_BIT = 2;
   localparam int PCMV_BURST_BIT = 3;
   localparam int PCMV_SLOTS_LSB = 4;
   localparam int PCMV_LSBF_BIT = 7;
   localparam int PCMV_RJ_BIT = 8;
   localparam int PCMV_FILL_LSB = 9;
   localparam int PCMV_FCONST_LSB = 11;
   localparam int PCMV_CHEN_LSB = 12;
   localparam int PCMV_BDIV_LSB = 8;
   // ***************************************************
   // reset values, sizes and fill mode codes
   // ***************************************************
   localparam int PCMV_NCH = 3;
   localparam logic [7:0] PCMV_DIV_RST = 8'h20;
   localparam logic [7:0] PCMV_BDIV_RST = 8'h03;
   localparam logic [2:0] PCMV_SLOTS_RST = 3'h0;
   localparam logic [1:0] PCMV_FILL_ZERO = 2'h0;
   localparam logic [1:0] PCMV_FILL_ONE = 2'h1;
   localparam logic [1:0] PCMV_FILL_SIGN = 2'h2;
   localparam logic [1:0] PCMV_FILL_CONST = 2'h3;
   // ***************************************************
   // timing: burst rate ceiling as a least half period
   // ***************************************************
   localparam longint PCMV_CLK_HZ = 125000000;
   localparam longint PCMV_BURST_MAX_HZ = 24000000;
   localparam logic [7:0] PCMV_BURST_MIN_HALF =
      8'((PCMV_CLK_HZ + 2 * PCMV_BURST_MAX_HZ - 1) / (2 * PCMV_BURST_MAX_HZ));
endpackage : pcmv_pkg

// [design/pcmv_fmt_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface pcmv_fmt_if;
   logic [12:0] tx_sample;
   logic [15:0] tx_word;
   logic [15:0] rx_word;
   logic [12:0] rx_sample;
   logic lsb_first;
   logic right_just;
   logic [1:0] fill_mode;
   logic [2:0] fill_const;
   modport user (output tx_sample, rx_word, lsb_first, right_just, fill_mode, fill_const,
                 input tx_word, rx_sample);
   modport fmt (input tx_sample, rx_word, lsb_first, right_just, fill_mode, fill_const,
                output tx_word, rx_sample);
endinterface : pcmv_fmt_if
`default_nettype wire

// [design/pcmv_fmt.sv]
`timescale 1ns/100ps
`default_nettype none
module pcmv_fmt (
   pcmv_fmt_if.fmt f
);
   import pcmv_pkg::*;
   logic [2:0] fill;
   logic [15:0] word;
   logic [15:0] rx_fwd;
   // ***************************************************
   // pack 13 bits into the 16 bit word and back
   // ***************************************************
   always_comb begin
      unique case (f.fill_mode)
         PCMV_FILL_ZERO: fill = 3'h0;
         PCMV_FILL_ONE: fill = 3'h7;
         PCMV_FILL_SIGN: fill = {3{f.tx_sample[12]}};
         PCMV_FILL_CONST: fill = f.fill_const;
      endcase
      // placement of the sample in the word
      word = f.right_just ? {fill, f.tx_sample} : {f.tx_sample, fill};
      for (int i = 0; i < 16; i++) begin
         f.tx_word[i] = f.lsb_first ? word[15 - i] : word[i];
         rx_fwd[i] = f.lsb_first ? f.rx_word[15 - i] : f.rx_word[i];
      end
      // unused three bits are dropped here
      f.rx_sample = f.right_just ? rx_fwd[12:0] : rx_fwd[15:3];
   end
endmodule : pcmv_fmt
`default_nettype wire

// [design/pcmv_port.sv]
`timescale 1ns/100ps
`default_nettype none
module pcmv_port (
   input wire logic clock_in,
   input wire logic sys_rst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic stereo_busy_in,
   output logic pcm_active_out,
   input wire logic pcm_clk_in,
   output logic pcm_clk_out,
   output logic pcm_clk_oe_n_out,
   input wire logic pcm_sync_in,
   output logic pcm_sync_out,
   output logic pcm_sync_oe_n_out,
   input wire logic pcm_din_in,
   output logic pcm_dout_out,
   output logic pcm_dout_oe_n_out
);
   import pcmv_pkg::*;

   // ***************************************************
   // state
   // ***************************************************
   typedef struct packed {
      logic [31:0] rdata;
      logic ready;
      logic slverr;
      logic enable;
      logic master;
      logic long_sync;
      logic burst;
      logic [2:0] slot_log2;
      logic lsb_first;
      logic right_just;
      logic [1:0] fill_mode;
      logic [2:0] fill_const;
      logic [7:0] div_norm;
      logic [7:0] div_burst;
      logic [11:0] ch_slot;
      logic [2:0] ch_en;
      logic [38:0] tx_smp;
      logic [38:0] rx_smp;
      logic [2:0] rx_rdy;
      logic [7:0] div_cnt;
      logic bclk;
      logic [2:0] clk_sy;
      logic [1:0] sync_sy;
      logic [1:0] din_sy;
      logic sync_prev;
      logic short_pend;
      logic [3:0] slot;
      logic [3:0] bitn;
      logic [15:0] tx_sh;
      logic [15:0] rx_sh;
      logic [1:0] rx_ch;
      logic rx_own;
      logic sync_o;
      logic dout;
      logic dout_oe_n;
      logic clk_oe_n;
      logic sync_oe_n;
      logic active;
   } pcmv_state_t;

   pcmv_state_t s_q;
   pcmv_state_t s_d;
   pcmv_fmt_if fi ();

   logic act;
   logic [7:0] half;
   logic tick;
   logic rise;
   logic fall;
   logic pend_go;
   logic [3:0] last_slot;
   logic [3:0] nslot;
   logic [3:0] nbit;
   logic [2:0] hit;
   logic [1:0] own_idx;
   logic [7:0] acc_ofs;

   // ***************************************************
   // link clock events
   // ***************************************************
   // the stereo port has priority while it runs
   assign act = s_q.enable & ~stereo_busy_in;
   // burst half period never below the 24 MHz bound
   assign half = !s_q.burst ? s_q.div_norm :
                 (s_q.div_burst < PCMV_BURST_MIN_HALF) ?
                 PCMV_BURST_MIN_HALF : s_q.div_burst;
   assign tick = (s_q.div_cnt >= half - 8'h01);
   // master makes edges, slave finds them in the synced pin
   assign rise = act & (s_q.master ? (tick & ~s_q.bclk)
                 : (s_q.clk_sy[1] & ~s_q.clk_sy[2]));
   assign fall = act & (s_q.master ? (tick & s_q.bclk)
                 : (~s_q.clk_sy[1] & s_q.clk_sy[2]));

   // ***************************************************
   // next slot position at a rising edge
   // ***************************************************
   // slot count per frame is a power of two up to 16
   assign last_slot = 4'((5'h01 << s_q.slot_log2) - 5'h01);
   assign pend_go = ~s_q.master & s_q.short_pend;
   assign nbit = pend_go ? 4'h0 : s_q.bitn + 4'h1;
   assign nslot = pend_go ? 4'h0 :
                  (s_q.bitn != 4'hf) ? s_q.slot :
                  (s_q.slot >= last_slot) ? 4'h0 : s_q.slot + 4'h1;

   // ***************************************************
   // channel ownership of the coming slot
   // ***************************************************
   genvar gi;
   generate
      for (gi = 0; gi < PCMV_NCH; gi++) begin : g_hit
         // one slot number serves both directions
         assign hit[gi] = s_q.ch_en[gi] &
                          (s_q.ch_slot[4 * gi +: 4] == nslot);
      end
   endgenerate
   assign own_idx = hit[0] ? 2'h0 : hit[1] ? 2'h1 : 2'h2;

   // ***************************************************
   // sample formatter
   // ***************************************************
   assign fi.tx_sample = s_q.tx_smp[13 * own_idx +: 13];
   assign fi.rx_word = {s_q.rx_sh[14:0], s_q.din_sy[1]};
   assign fi.lsb_first = s_q.lsb_first;
   assign fi.right_just = s_q.right_just;
   assign fi.fill_mode = s_q.fill_mode;
   assign fi.fill_const = s_q.fill_const;

   pcmv_fmt u_fmt (
      .f(fi.fmt)
   );

   assign acc_ofs = {paddr_in[7:2], 2'h0};

   // ***************************************************
   // next state
   // ***************************************************
   always_comb begin
      s_d = s_q;
      // synchronisers for the three link pins
      s_d.clk_sy = {s_q.clk_sy[1:0], pcm_clk_in};
      s_d.sync_sy = {s_q.sync_sy[0], pcm_sync_in};
      s_d.din_sy = {s_q.din_sy[0], pcm_din_in};
      s_d.active = act;
      s_d.clk_oe_n = ~(act & s_q.master);
      s_d.sync_oe_n = ~(act & s_q.master);

      // apb: answer one cycle after the access phase opens
      s_d.ready = psel_in & penable_in & ~s_q.ready;
      if (psel_in & penable_in & ~s_q.ready) begin
         s_d.rdata = 32'h0;
         s_d.slverr = 1'b0;
         unique case (acc_ofs)
            PCMV_CTRL_OFS: begin
               s_d.rdata[PCMV_EN_BIT] = s_q.enable;
               s_d.rdata[PCMV_MST_BIT] = s_q.master;
               s_d.rdata[PCMV_LONG_BIT] = s_q.long_sync;
               s_d.rdata[PCMV_BURST_BIT] = s_q.burst;
               s_d.rdata[PCMV_SLOTS_LSB +: 3] = s_q.slot_log2;
               s_d.rdata[PCMV_LSBF_BIT] = s_q.lsb_first;
               s_d.rdata[PCMV_RJ_BIT] = s_q.right_just;
               s_d.rdata[PCMV_FILL_LSB +: 2] = s_q.fill_mode;
               s_d.rdata[PCMV_FCONST_LSB +: 3] = s_q.fill_const;
            end
            PCMV_DIV_OFS: begin
               s_d.rdata[15:0] = {s_q.div_burst, s_q.div_norm};
            end
            PCMV_CHAN_OFS: begin
               s_d.rdata[14:0] = {s_q.ch_en, s_q.ch_slot};
            end
            PCMV_STAT_OFS: begin
               s_d.rdata[11:0] = {s_q.slot, s_q.active, s_q.rx_rdy, s_q.bitn[3:3], 3'h0};
            end
            PCMV_TX0_OFS, PCMV_TX0_OFS + 8'h04, PCMV_TX0_OFS + 8'h08: begin
               s_d.rdata[12:0] = s_q.tx_smp[13 * (acc_ofs[3:2] - 2'h0) +: 13];
            end
            PCMV_RX0_OFS, PCMV_RX0_OFS + 8'h04, PCMV_RX0_OFS + 8'h08: begin
               s_d.rdata[12:0] = s_q.rx_smp[13 * 2'(acc_ofs[3:2] - 2'h3) +: 13];
            end
            default: begin
               s_d.slverr = 1'b1; // unmapped word
            end
         endcase
      end else begin
         s_d.slverr = 1'b0;
      end

      // writes land on the edge that completes the transfer
      if (psel_in & penable_in & s_q.ready & pwrite_in & ~s_q.slverr) begin
         unique case (acc_ofs)
            PCMV_CTRL_OFS: begin
               s_d.enable = pwdata_in[PCMV_EN_BIT];
               s_d.master = pwdata_in[PCMV_MST_BIT];
               s_d.long_sync = pwdata_in[PCMV_LONG_BIT];
               s_d.burst = pwdata_in[PCMV_BURST_BIT];
               s_d.slot_log2 = (pwdata_in[PCMV_SLOTS_LSB +: 3] > 3'h4) ?
                               3'h4 : pwdata_in[PCMV_SLOTS_LSB +: 3];
               s_d.lsb_first = pwdata_in[PCMV_LSBF_BIT];
               s_d.right_just = pwdata_in[PCMV_RJ_BIT];
               s_d.fill_mode = pwdata_in[PCMV_FILL_LSB +: 2];
               s_d.fill_const = pwdata_in[PCMV_FCONST_LSB +: 3];
            end
            PCMV_DIV_OFS: begin
               s_d.div_norm = (pwdata_in[7:0] == 8'h0) ? 8'h01 : pwdata_in[7:0];
               s_d.div_burst = pwdata_in[PCMV_BDIV_LSB +: 8];
            end
            PCMV_CHAN_OFS: begin
               s_d.ch_slot = pwdata_in[11:0];
               s_d.ch_en = pwdata_in[PCMV_CHEN_LSB +: 3];
            end
            PCMV_TX0_OFS, PCMV_TX0_OFS + 8'h04, PCMV_TX0_OFS + 8'h08: begin
               s_d.tx_smp[13 * (acc_ofs[3:2] - 2'h0) +: 13] = pwdata_in[12:0];
            end
            default: begin
            end
         endcase
      end

      // ***************************************************
      // master bit clock divider
      // ***************************************************
      if (!act || !s_q.master || tick) begin
         s_d.div_cnt = 8'h0;
      end else begin
         s_d.div_cnt = s_q.div_cnt + 8'h01;
      end
      if (!act || !s_q.master) begin
         s_d.bclk = 1'b0;
      end else if (tick) begin
         s_d.bclk = ~s_q.bclk;
      end

      // ***************************************************
      // rising edge: advance position and drive data
      // ***************************************************
      if (rise) begin
         s_d.slot = nslot;
         s_d.bitn = nbit;
         s_d.short_pend = 1'b0;
         // master sync: short in last bit, long in first three
         if (s_q.long_sync) begin
            s_d.sync_o = (nslot == 4'h0) & (nbit < 4'h3);
         end else begin
            s_d.sync_o = (nslot == last_slot) & (nbit == 4'hf);
         end
         if (nbit == 4'h0) begin
            s_d.rx_own = |hit;
            s_d.rx_ch = own_idx;
            s_d.tx_sh = {fi.tx_word[14:0], 1'b0};
            s_d.dout = fi.tx_word[15];
            s_d.dout_oe_n = ~(|hit);
         end else begin
            s_d.tx_sh = {s_q.tx_sh[14:0], 1'b0};
            s_d.dout = s_q.tx_sh[15];
         end
      end

      // ***************************************************
      // falling edge: capture data and sample sync
      // ***************************************************
      if (fall) begin
         s_d.sync_prev = s_q.sync_sy[1];
         if (!s_q.master && !s_q.long_sync && s_q.sync_sy[1]) begin
            s_d.short_pend = 1'b1;
         end
         // long sync rising marks bit 0 of slot 0
         if (!s_q.master && s_q.long_sync && s_q.sync_sy[1] && !s_q.sync_prev) begin
            s_d.slot = 4'h0;
            s_d.bitn = 4'h0;
         end
         if (s_q.rx_own) begin
            s_d.rx_sh = {s_q.rx_sh[14:0], s_q.din_sy[1]};
         end
         if (s_q.bitn == 4'hf) begin
            s_d.dout_oe_n = 1'b1;
            if (s_q.rx_own) begin
               s_d.rx_smp[13 * s_q.rx_ch +: 13] = fi.rx_sample;
            end
         end
      end

      // receive flags: a new sample wins over a clear
      if (psel_in & penable_in & s_q.ready & pwrite_in & (acc_ofs == PCMV_STAT_OFS)) begin
         s_d.rx_rdy = s_q.rx_rdy & ~pwdata_in[6:4];
      end
      if (fall && s_q.bitn == 4'hf && s_q.rx_own) begin
         s_d.rx_rdy[s_q.rx_ch] = 1'b1;
      end

      // port idle: position cleared and data released
      if (!act) begin
         s_d.slot = 4'h0;
         s_d.bitn = 4'hf;
         s_d.short_pend = 1'b0;
         s_d.rx_own = 1'b0;
         s_d.sync_o = 1'b0;
         s_d.dout_oe_n = 1'b1;
      end

      // synchronous reset to the documented defaults
      if (sys_rst_in) begin
         s_d = '0;
         s_d.div_norm = PCMV_DIV_RST;
         s_d.div_burst = PCMV_BDIV_RST;
         s_d.slot_log2 = PCMV_SLOTS_RST;
         s_d.fill_mode = PCMV_FILL_ZERO;
         s_d.bitn = 4'hf;
         s_d.dout_oe_n = 1'b1;
         s_d.clk_oe_n = 1'b1;
         s_d.sync_oe_n = 1'b1;
      end
   end

   // ***************************************************
   // state register
   // ***************************************************
   always_ff @(posedge clock_in) begin
      s_q <= s_d;
   end

   // ***************************************************
   // outputs straight from flip-flops
   // ***************************************************
   assign prdata_out = s_q.rdata;
   assign pready_out = s_q.ready;
   assign pslverr_out = s_q.slverr;
   assign pcm_active_out = s_q.active;
   assign pcm_clk_out = s_q.bclk;
   assign pcm_clk_oe_n_out = s_q.clk_oe_n;
   assign pcm_sync_out = s_q.sync_o;
   assign pcm_sync_oe_n_out = s_q.sync_oe_n;
   assign pcm_dout_out = s_q.dout;
   assign pcm_dout_oe_n_out = s_q.dout_oe_n;
endmodule : pcmv_port
`default_nettype wire

// [tb/pcmv_port_properties.sv]
`timescale 1ns/100ps
`default_nettype none
module pcmv_port_properties (
   input wire logic clock_in,
   input wire logic sys_rst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] prdata_out,
   input wire logic pready_out,
   input wire logic pslverr_out,
   input wire logic stereo_busy_in,
   input wire logic pcm_active_out,
   input wire logic pcm_clk_out,
   input wire logic pcm_clk_oe_n_out,
   input wire logic pcm_sync_out,
   input wire logic pcm_sync_oe_n_out,
   input wire logic pcm_dout_out,
   input wire logic pcm_dout_oe_n_out
);
   // ***************************************************
   // helper: bit clock falls seen inside the sync pulse
   // ***************************************************
   logic clk_prev_q;
   logic [3:0] sync_falls_q;
   // counts falls while sync is high, clears while low
   always_ff @(posedge clock_in) begin
      clk_prev_q <= pcm_clk_out;
      if (!pcm_sync_out) begin
         sync_falls_q <= 4'h0;
      end else if (clk_prev_q && !pcm_clk_out) begin
         sync_falls_q <= sync_falls_q + 4'h1;
      end
   end
   // ***************************************************
   // properties
   // ***************************************************
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (sys_rst_in);
   sequence s_access; psel_in && penable_in && !pready_out; endsequence
   sequence s_idle2; !pcm_active_out ##1 !pcm_active_out; endsequence
   property p_ready_one; s_access |=> pready_out ##1 !pready_out; endproperty
   a_ready_one: assert property (p_ready_one) else $error("pready is not one pulse after access");
   property p_ready_cause; pready_out |-> $past(psel_in && penable_in); endproperty
   a_ready_cause: assert property (p_ready_cause) else $error("pready without access");
   property p_unmapped; s_access and paddr_in >= 8'h28 |=> pslverr_out && prdata_out == 32'h0; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
   property p_err_ready; pslverr_out |-> pready_out; endproperty
   a_err_ready: assert property (p_err_ready) else $error("pslverr outside pready");
   property p_dir_pair; pcm_sync_oe_n_out == pcm_clk_oe_n_out; endproperty
   a_dir_pair: assert property (p_dir_pair) else $error("clock and sync direction differ");
   property p_idle_float; s_idle2 |-> pcm_clk_oe_n_out && pcm_dout_oe_n_out; endproperty
   a_idle_float: assert property (p_idle_float) else $error("pins driven while idle");
   property p_busy_idle; $rose(stereo_busy_in) |-> ##[1:2] !pcm_active_out; endproperty
   a_busy_idle: assert property (p_busy_idle) else $error("port active beside stereo port");
   property p_sync_width;
      $fell(pcm_sync_out) && !pcm_sync_oe_n_out |-> sync_falls_q == 4'h1 || sync_falls_q == 4'h3;
   endproperty
   a_sync_width: assert property (p_sync_width) else $error("sync not one or three bits");
   property p_dout_rise;
      !pcm_clk_oe_n_out && !pcm_dout_oe_n_out && $past(!pcm_dout_oe_n_out) && $changed(pcm_dout_out)
      |-> pcm_clk_out;
   endproperty
   a_dout_rise: assert property (p_dout_rise) else $error("data changed in clock low half");
   property p_release_fall; $rose(pcm_dout_oe_n_out) && !pcm_clk_oe_n_out |-> !pcm_clk_out; endproperty
   a_release_fall: assert property (p_release_fall) else $error("data released outside low half");
   property p_burst_cap; $rose(pcm_clk_out) |=> (pcm_clk_out || pcm_clk_oe_n_out) [*2]; endproperty
   a_burst_cap: assert property (p_burst_cap) else $error("bit clock high half too short");
endmodule : pcmv_port_properties
bind pcmv_port pcmv_port_properties u_props (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
   .psel_in(psel_in), .penable_in(penable_in), .paddr_in(paddr_in), .prdata_out(prdata_out),
   .pready_out(pready_out), .pslverr_out(pslverr_out), .stereo_busy_in(stereo_busy_in),
   .pcm_active_out(pcm_active_out), .pcm_clk_out(pcm_clk_out), .pcm_clk_oe_n_out(pcm_clk_oe_n_out),
   .pcm_sync_out(pcm_sync_out), .pcm_sync_oe_n_out(pcm_sync_oe_n_out), .pcm_dout_out(pcm_dout_out),
   .pcm_dout_oe_n_out(pcm_dout_oe_n_out));
`default_nettype wire

// [tb/pcmv_codec_model.sv]
`timescale 1ns/100ps
`default_nettype none
module pcmv_codec_model #(parameter int FBITS = 32) (
   input wire logic run_in,
   input wire logic long_in,
   input wire logic [3:0] slot_in,
   input wire logic [15:0] word_in,
   input wire logic dout_in,
   input wire logic dout_oe_n_in,
   output logic clk_out,
   output logic sync_out,
   output logic din_out,
   output logic busy_out,
   output logic float_bad_out,
   output logic [15:0] got_out
);
   int f;
   int b;
   // ***************************************************
   // far master: three frames per run, clock still between runs
   // ***************************************************
   initial begin
      {clk_out, sync_out, din_out, busy_out, float_bad_out} = 5'h00;
      got_out = 16'h0000;
      forever begin
         wait (run_in);
         busy_out = 1'b1;
         float_bad_out = 1'b0;
         #3;
         for (f = 0; f < 3; f++) begin
            for (b = 0; b < FBITS; b++) begin
               clk_out = 1'b1;
               sync_out = long_in ? (b < 3) : (b == FBITS - 1);
               din_out = (b / 16 == slot_in) ? word_in[15 - b % 16] : ~din_out;
               #32;
               clk_out = 1'b0;
               // capture on the fall; outside our slot, after the first frame, the device must float
               if (b / 16 == slot_in) begin
                  got_out[15 - b % 16] = dout_in;
               end else if (f > 0 && !dout_oe_n_in) begin
                  float_bad_out = 1'b1;
               end
               #32;
            end
         end
         sync_out = 1'b0;
         din_out = ~din_out;
         busy_out = 1'b0;
         wait (!run_in);
      end
   end
endmodule : pcmv_codec_model
`default_nettype wire

// [tb/tb_pcmv_port.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_pcmv_port;
   import pcmv_pkg::*;
   logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, stereo = 1'b0, run = 1'b0, slng = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, active, clk_o, clk_oe_n, sync_o, sync_oe_n, dout, dout_oe_n;
   logic m_clk, m_sync, m_din, m_busy, m_bad;
   logic [15:0] m_got;
   logic [6:0] cfgs [6] = '{7'h00, 7'h04, 7'h08, 7'h5c, 7'h01, 7'h0a};
   int err_count = 0, total_checks = 0;
   // wire levels from the device's enables alone
   wire logic clk_w = clk_oe_n ? m_clk : clk_o;
   wire logic sync_w = sync_oe_n ? m_sync : sync_o;
   // 125 MHz system clock
   always #4 clk = ~clk;
   pcmv_port u_dut (.clock_in(clk), .sys_rst_in(rst), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
      .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
      .stereo_busy_in(stereo), .pcm_active_out(active), .pcm_clk_in(clk_w), .pcm_clk_out(clk_o),
      .pcm_clk_oe_n_out(clk_oe_n), .pcm_sync_in(sync_w), .pcm_sync_out(sync_o), .pcm_sync_oe_n_out(sync_oe_n),
      .pcm_din_in(m_din), .pcm_dout_out(dout), .pcm_dout_oe_n_out(dout_oe_n));
   pcmv_codec_model #(.FBITS(32)) u_codec (.run_in(run), .slot_in(4'h1), .word_in(16'h9c3b), .dout_in(dout),
      .dout_oe_n_in(dout_oe_n), .clk_out(m_clk), .sync_out(m_sync), .din_out(m_din), .busy_out(m_busy),
      .float_bad_out(m_bad), .got_out(m_got), .long_in(slng));
   // ***************************************************
   // helpers
   // ***************************************************
   task summarize;
      $display("errors %0d checks %0d", err_count, total_checks);
      if (err_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : summarize
   task chk(input logic [31:0] g, input logic [31:0] e, input string m);
      total_checks++;
      if (g !== e) begin
         err_count++;
         $display("BAD %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask : chk
   // one apb transfer, held until pready is seen at an edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      if (n >= 20) chk(32'h0, 32'h1, "no pready");
   endtask : apb
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask : wr
   task rd(input logic [7:0] a, output logic [31:0] q);
      logic e;
      apb(1'b0, a, 32'h0, q, e);
   endtask : rd
   // cfg: [0] lsb first, [1] right justified, [3:2] fill, [6:4] fill constant
   function automatic logic [15:0] exp_word(input logic [12:0] s, input logic [6:0] c);
      logic [2:0] p;
      logic [15:0] w;
      p = (c[3:2] == PCMV_FILL_ZERO) ? 3'h0 : (c[3:2] == PCMV_FILL_ONE) ? 3'h7 :
          (c[3:2] == PCMV_FILL_SIGN) ? {3{s[12]}} : c[6:4];
      w = c[1] ? {p, s} : {s, p};
      if (c[0]) w = {<<{w}};
      return w;
   endfunction : exp_word
   function automatic logic [12:0] exp_rx(input logic [15:0] w, input logic [6:0] c);
      logic [15:0] v;
      v = w;
      if (c[0]) v = {<<{w}};
      return c[1] ? v[12:0] : v[15:3];
   endfunction : exp_rx
   // ***************************************************
   // scenarios
   // ***************************************************
   task t_reset;
      logic [31:0] q;
      logic e;
      chk(32'(dout_oe_n & clk_oe_n & sync_oe_n), 32'h1, "floating after reset");
      rd(PCMV_CTRL_OFS, q);
      chk(q, 32'h0, "ctrl reset");
      rd(PCMV_DIV_OFS, q);
      chk(q, {16'h0, PCMV_BDIV_RST, PCMV_DIV_RST}, "div reset");
      apb(1'b0, 8'h40, 32'h0, q, e);
      chk(q, 32'h0, "unmapped data");
      chk(32'(e), 32'h1, "unmapped error");
   endtask : t_reset
   // slave, two slots, channel 0 in slot 1, every format choice
   task t_slave;
      logic [31:0] q;
      logic [6:0] c;
      int i, n;
      wr(PCMV_CHAN_OFS, 32'h1001);
      wr(PCMV_TX0_OFS, 32'h1a5c);
      for (i = 0; i < 6; i++) begin
         c = cfgs[i];
         wr(PCMV_CTRL_OFS, (32'(c[0]) << PCMV_LSBF_BIT) | (32'(c[1]) << PCMV_RJ_BIT) |
            (32'(c[3:2]) << PCMV_FILL_LSB) | (32'(c[6:4]) << PCMV_FCONST_LSB) |
            (32'(i == 5) << PCMV_LONG_BIT) | 32'h11);
         chk(32'(clk_oe_n), 32'h1, "slave drives clock");
         slng <= (i == 5);
         run <= 1'b1;
         n = 0;
         @(posedge clk);
         while (m_busy !== 1'b0 && n < 3000) begin
            @(posedge clk);
            n++;
         end
         run <= 1'b0;
         chk(32'(n < 3000), 32'h1, "link hang");
         chk(32'(m_got), 32'(exp_word(13'h1a5c, c)), "tx word");
         chk(32'(m_bad), 32'h0, "drove foreign slot");
         rd(PCMV_RX0_OFS, q);
         chk(q, 32'(exp_rx(16'h9c3b, c)), "rx sample");
         rd(PCMV_STAT_OFS, q);
         chk(32'(q[4]), 32'h1, "rx ready");
         wr(PCMV_STAT_OFS, 32'h10);
         rd(PCMV_STAT_OFS, q);
         chk(32'(q[4]), 32'h0, "rx ready clear");
      end
   endtask : t_slave
   // master sync width in system clocks; burst half 2 must clamp to 3
   task t_master(input logic lng, input logic bst, input int width);
      int n, k;
      n = 0;
      k = 0;
      wr(PCMV_CTRL_OFS, 32'h0);
      wr(PCMV_DIV_OFS, 32'h0204);
      wr(PCMV_CTRL_OFS, 32'h13 | (32'(lng) << PCMV_LONG_BIT) | (32'(bst) << PCMV_BURST_BIT));
      while (sync_o !== 1'b1 && k < 500) begin
         @(posedge clk);
         k++;
      end
      while (sync_o === 1'b1 && k < 500) begin
         @(posedge clk);
         k++;
         n++;
      end
      chk(32'(n), 32'(width), "sync width");
      chk(32'(clk_oe_n | sync_oe_n), 32'h0, "master drives");
   endtask : t_master
   task t_stereo;
      stereo <= 1'b1;
      repeat (4) @(posedge clk);
      chk(32'(active), 32'h0, "active beside stereo");
      chk(32'(clk_oe_n & dout_oe_n), 32'h1, "pins beside stereo");
      stereo <= 1'b0;
      repeat (4) @(posedge clk);
      chk(32'(active), 32'h1, "active again");
   endtask : t_stereo
   // ***************************************************
   // main sequence and watchdog
   // ***************************************************
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset;
      t_slave;
      t_master(1'b0, 1'b0, 8);
      t_master(1'b1, 1'b0, 24);
      t_master(1'b1, 1'b1, 18);
      t_stereo;
      summarize;
   end
   initial begin
      #200000;
      err_count++;
      summarize;
   end
endmodule : tb_pcmv_port
`default_nettype wire
